// [bei_buffer.sv]
// Small shift-style FIFO; the head entry is always in slot zero.
// Assumes both sides sit on the same clock; ready is registered.
`timescale 1ns/10ps
module bei_buffer #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Draining side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic [CW-1:0]    wr_slot;
    logic             push;
    logic             pop;

    // Handshakes and fill level
    assign push       = in_valid & in_ready;
    assign pop        = out_valid & out_ready;
    assign wr_slot    = count_reg - CW'(pop);
    assign count_next = count_reg + CW'(push) - CW'(pop);

    // Fill level and registered flags
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            count_reg <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            in_ready  <= (count_next != FULL_CNT);
            out_valid <= (count_next != '0);
        end
    end

    // Entries shift toward the head on a pop
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_slot
        always_ff @(posedge clk)
        begin
            if (!rst_n)
                mem_reg[i] <= '0;
            else if (push && wr_slot == CW'(i))
                mem_reg[i] <= in_data;
            else if (pop && i < DEPTH - 1)
                mem_reg[i] <= mem_reg[(i < DEPTH - 1) ? i + 1 : i];
        end
    end

    assign out_data = mem_reg[0];

endmodule : bei_buffer

// [bei_far_end.sv]
// Far-side model: serial receiver with stalls and detector timing source.
// Assumes one bit clock; clr zeroes the statistics except gap.
`timescale 1ns/10ps
module bei_far_end (
    // Clock and control
    input  wire logic       clk,
    input  wire logic       clr,
    input  wire logic [1:0] mode,
    input  wire logic       tick_en,
    // Stream and timing
    input  wire logic       data_out,
    input  wire logic       data_valid,
    output logic            data_ready = 1'b0,
    output logic            det_tick = 1'b0,
    // Statistics
    output int              ones,
    output int              breaks,
    output int              gap,
    output int              ticks
);
    int         n;
    int         last_one;
    logic       last_bit;
    logic [1:0] ph = 2'h0;

    // Ready: 0 always, 1 one stall in four, 2 held off
    always @(posedge clk)
    begin
        ph <= ph + 2'h1;
        data_ready <= (mode == 2'h0) || (mode == 2'h1 && ph != 2'h3);
    end
    // Accepted bit statistics
    always @(posedge clk)
    begin
        if (clr)
        begin
            n = 0;
            ones = 0;
            breaks = 0;
            last_one = 0;
            ticks = 0;
        end
        else if (data_valid && data_ready)
        begin
            n = n + 1;
            if (n > 1 && data_out == last_bit)
                breaks = breaks + 1;
            if (data_out)
            begin
                gap = n - last_one;
                last_one = n;
                ones = ones + 1;
            end
            last_bit = data_out;
        end
    end
    // Detector timing, unrelated to the bit clock; still when off
    // Each level lasts over two bit clocks so the synchroniser sees it twice
    always #13
        det_tick = tick_en ? ~det_tick : 1'b0;
    always @(posedge det_tick)
        ticks = ticks + 1;
endmodule : bei_far_end

// [bei_inserter.sv]
// Error insertion and sync pulse for one pattern generator channel.
// Assumes MCLK is the bit clock; the detector tick arrives unsynchronised.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
module bei_inserter
    import bei_pkg::*;
#(
    parameter int          BUF_DEPTH  = 2,
    parameter int unsigned RATE_SHIFT = 0
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // Pattern source
    input  wire logic        PAT_DATA,
    input  wire logic        PAT_VALID,
    output logic             PAT_READY,
    // Serial data toward the output stage
    output logic             DATA_OUT,
    output logic             DATA_VALID,
    input  wire logic        DATA_READY,
    // Detector timing and sync output
    input  wire logic        DET_TICK,
    output logic             SYNC_OUT,
    // Status lamp
    output logic             INSERT_LAMP
);
    import bei_pkg::*;

    // Control register fields
    logic        en_reg;
    logic        repeat_reg;
    logic        loaded_reg;
    logic        src_det_reg;
    logic [3:0]  rate_reg;
    logic [2:0]  gdiv_reg;
    logic [1:0]  ddiv_reg;
    logic [20:0] patlen_reg;
    logic [15:0] err_cnt_reg;
    logic [31:0] rdata_reg;

    // Stream state
    logic        alt_reg;
    logic        src_bit;
    logic        src_valid;
    logic        buf_ready;
    logic        take;
    logic        inject;
    logic        out_bit;

    // Single-shot and repeat state
    bei_ss_t     ss_reg;
    bei_ss_t     ss_next;
    logic        lamp_reg;
    logic [39:0] rpt_cnt_reg;
    logic [39:0] rpt_reload;
    logic        rpt_hit;
    logic        insert_cmd;

    // Sync state
    logic [2:0]  det_sync_reg;
    logic        det_level_reg;
    logic        det_edge;
    logic        tick;
    logic [20:0] pat_pos_reg;
    logic [20:0] pat_len;
    logic [5:0]  div_cnt_reg;
    logic [5:0]  div_last;
    logic        sync_reg;
    logic        sync_next;

    // Register decode
    logic        wr_ctrl;
    logic        wr_cmd;
    logic        wr_patlen;

    assign wr_ctrl    = WR && (ADDR == BEI_OFS_CTRL);
    assign wr_cmd     = WR && (ADDR == BEI_OFS_CMD);
    assign wr_patlen  = WR && (ADDR == BEI_OFS_PATLEN);
    assign insert_cmd = wr_cmd && WDATA[BEI_CMD_INSERT];

    // Control register
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            en_reg      <= BEI_CTRL_RESET[BEI_CTRL_EN];
            repeat_reg  <= BEI_CTRL_RESET[BEI_CTRL_REPEAT];
            loaded_reg  <= BEI_CTRL_RESET[BEI_CTRL_LOADED];
            src_det_reg <= BEI_CTRL_RESET[BEI_CTRL_SRC_DET];
            rate_reg    <= BEI_CTRL_RESET[BEI_CTRL_RATE_LO +: 4];
            gdiv_reg    <= BEI_CTRL_RESET[BEI_CTRL_GDIV_LO +: 3];
            ddiv_reg    <= BEI_CTRL_RESET[BEI_CTRL_DDIV_LO +: 2];
        end
        else if (wr_ctrl)
        begin
            en_reg      <= WDATA[BEI_CTRL_EN];
            repeat_reg  <= WDATA[BEI_CTRL_REPEAT];
            loaded_reg  <= WDATA[BEI_CTRL_LOADED];
            src_det_reg <= WDATA[BEI_CTRL_SRC_DET];
            // Rates past the last decade clamp to it
            if (WDATA[BEI_CTRL_RATE_LO +: 4] > BEI_RATE_LAST)
                rate_reg <= BEI_RATE_LAST;
            else
                rate_reg <= WDATA[BEI_CTRL_RATE_LO +: 4];
            // Reserved divide codes fall back to the first entry
            if (WDATA[BEI_CTRL_GDIV_LO +: 3] > BEI_GDIV_PAT)
                gdiv_reg <= BEI_GDIV_1;
            else
                gdiv_reg <= WDATA[BEI_CTRL_GDIV_LO +: 3];
            if (WDATA[BEI_CTRL_DDIV_LO +: 2] > BEI_DDIV_16)
                ddiv_reg <= BEI_DDIV_4;
            else
                ddiv_reg <= WDATA[BEI_CTRL_DDIV_LO +: 2];
        end
    end

    // Pattern length register, held within the storable range
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            patlen_reg <= BEI_PATLEN_RESET;
        else if (wr_patlen)
        begin
            if (WDATA[20:0] > BEI_PATLEN_MAX)
                patlen_reg <= BEI_PATLEN_MAX;
            else if (WDATA[20:0] == '0)
                patlen_reg <= BEI_PATLEN_RESET;
            else
                patlen_reg <= WDATA[20:0];
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            rdata_reg <= '0;
        else if (!RD)
            rdata_reg <= '0;
        else
        begin
            case (ADDR)
                BEI_OFS_CTRL:
                    rdata_reg <= {19'h00000, ddiv_reg, gdiv_reg, rate_reg,
                                  src_det_reg, loaded_reg, repeat_reg, en_reg};
                BEI_OFS_PATLEN:
                    rdata_reg <= {11'h000, patlen_reg};
                BEI_OFS_STATUS:
                    rdata_reg <= {err_cnt_reg, 13'h0000, ss_reg == BEI_SS_ARMED,
                                  lamp_reg, DATA_VALID};
                default:
                    rdata_reg <= '0;
            endcase
        end
    end

    assign RDATA = rdata_reg;

    // Source selection: stored pattern or alternating fill
    assign src_bit   = loaded_reg ? PAT_DATA : alt_reg;
    assign src_valid = loaded_reg ? PAT_VALID : 1'b1;
    assign take      = src_valid && buf_ready;

    // Alternating fill toggles on every bit taken
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            alt_reg <= 1'b0;
        else if (take && !loaded_reg)
            alt_reg <= ~alt_reg;
    end

    // Single-shot state: armed by command, fired on the next bit
    always_comb
    begin
        ss_next = ss_reg;
        case (ss_reg)
            BEI_SS_IDLE:
                if (insert_cmd && en_reg && !repeat_reg)
                    ss_next = BEI_SS_ARMED;
            BEI_SS_ARMED:
                if (!en_reg || repeat_reg)
                    ss_next = BEI_SS_IDLE;
                else if (take)
                    ss_next = BEI_SS_HIT;
            BEI_SS_HIT:
                // A command in this cycle is kept, not dropped
                if (insert_cmd && en_reg && !repeat_reg)
                    ss_next = BEI_SS_ARMED;
                else
                    ss_next = BEI_SS_IDLE;
            default:
                ss_next = BEI_SS_IDLE;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            ss_reg <= BEI_SS_IDLE;
        else
            ss_reg <= ss_next;
    end

    // Lamp lights from arming through the corrupted bit
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            lamp_reg <= 1'b0;
        else
            lamp_reg <= (ss_next != BEI_SS_IDLE);
    end

    assign INSERT_LAMP = lamp_reg;

    // Repeat spacing: reload with the bit count of the selected rate
    assign rpt_reload = (BEI_RATE_PERIOD[rate_reg] >> RATE_SHIFT) - 40'h1;
    assign rpt_hit    = (rpt_cnt_reg == '0);

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            rpt_cnt_reg <= '0;
        else if (!en_reg || !repeat_reg)
            rpt_cnt_reg <= rpt_reload;
        else if (take)
        begin
            if (rpt_hit)
                rpt_cnt_reg <= rpt_reload;
            else
                rpt_cnt_reg <= rpt_cnt_reg - 40'h1;
        end
    end

    // One bit inverted per event, all others unchanged
    assign inject  = take && en_reg &&
                     ((!repeat_reg && ss_reg == BEI_SS_ARMED) ||
                      (repeat_reg && rpt_hit));
    assign out_bit = src_bit ^ inject;

    // Count of inserted errors for software
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            err_cnt_reg <= '0;
        else if (inject)
            err_cnt_reg <= err_cnt_reg + 16'h0001;
    end

    // Buffer lets the output stage stall without losing a bit
    bei_buffer #(
        .WIDTH (1),
        .DEPTH (BUF_DEPTH)
    ) u_buffer (
        .clk       (MCLK),
        .rst_n     (RST_N),
        .in_valid  (src_valid),
        .in_data   (out_bit),
        .in_ready  (buf_ready),
        .out_valid (DATA_VALID),
        .out_data  (DATA_OUT),
        .out_ready (DATA_READY)
    );

    assign PAT_READY = buf_ready;

    // Detector timing: three stages, rising change counts when last two agree
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            det_sync_reg <= '0;
        else
            det_sync_reg <= {det_sync_reg[1:0], DET_TICK};
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            det_level_reg <= 1'b0;
        else if (det_sync_reg[1] == det_sync_reg[2])
            det_level_reg <= det_sync_reg[2];
    end

    assign det_edge = (det_sync_reg[1] == det_sync_reg[2]) &&
                      det_sync_reg[2] && !det_level_reg;

    // Tick of the selected timing source
    assign tick = src_det_reg ? det_edge : take;

    // Position within the pattern, wraps once per repetition
    assign pat_len = loaded_reg ? patlen_reg : BEI_ALT_LEN;

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            pat_pos_reg <= '0;
        else if (take)
        begin
            if (pat_pos_reg >= pat_len - 21'h1)
                pat_pos_reg <= '0;
            else
                pat_pos_reg <= pat_pos_reg + 21'h1;
        end
    end

    // Last count value of the selected divider
    always_comb
    begin
        div_last = 6'h00;
        if (src_det_reg)
        begin
            case (ddiv_reg)
                BEI_DDIV_4:  div_last = 6'h03;
                BEI_DDIV_8:  div_last = 6'h07;
                BEI_DDIV_16: div_last = 6'h0F;
                default:     div_last = 6'h03;
            endcase
        end
        else
        begin
            case (gdiv_reg)
                BEI_GDIV_1:  div_last = 6'h00;
                BEI_GDIV_2:  div_last = 6'h01;
                BEI_GDIV_4:  div_last = 6'h03;
                BEI_GDIV_8:  div_last = 6'h07;
                BEI_GDIV_16: div_last = 6'h0F;
                BEI_GDIV_64: div_last = 6'h3F;
                default:     div_last = 6'h00;
            endcase
        end
    end

    // Divider counts source ticks
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            div_cnt_reg <= '0;
        else if (tick)
        begin
            if (div_cnt_reg >= div_last)
                div_cnt_reg <= '0;
            else
                div_cnt_reg <= div_cnt_reg + 6'h01;
        end
    end

    // One-cycle sync pulse per divided tick or per pattern
    always_comb
    begin
        if (!src_det_reg && gdiv_reg == BEI_GDIV_PAT)
            sync_next = take && (pat_pos_reg == '0);
        else
            sync_next = tick && (div_cnt_reg >= div_last);
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            sync_reg <= 1'b0;
        else
            sync_reg <= sync_next;
    end

    assign SYNC_OUT = sync_reg;

endmodule : bei_inserter

// [bei_inserter_chk.sv]
// Port-level checker for the error inserter, bound to every instance.
// Assumes software writes only legal control values.
`timescale 1ns/10ps
module bei_inserter_chk
    import bei_pkg::*;
(
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST_N,
    // Register port
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    // Stream
    input wire logic        PAT_VALID,
    input wire logic        PAT_READY,
    input wire logic        DATA_OUT,
    input wire logic        DATA_VALID,
    input wire logic        DATA_READY,
    // Sync and lamp
    input wire logic        DET_TICK,
    input wire logic        SYNC_OUT,
    input wire logic        INSERT_LAMP
);
    logic [12:0] ctrl_q;
    logic [2:0]  rx_n;
    logic        rx_last;
    logic        take;
    logic        cmd;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    // Shadow of the control word and the delivered-bit history
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            ctrl_q <= BEI_CTRL_RESET;
        else if (WR && ADDR == BEI_OFS_CTRL)
            ctrl_q <= WDATA[12:0];
    end
    always_ff @(posedge MCLK)
    begin
        if (!RST_N || (WR && ADDR == BEI_OFS_CTRL))
            rx_n <= 3'h0;
        else if (DATA_VALID && DATA_READY && rx_n != 3'h7)
            rx_n <= rx_n + 3'h1;
    end
    always_ff @(posedge MCLK)
    begin
        if (DATA_VALID && DATA_READY)
            rx_last <= DATA_OUT;
    end
    // Source bit accepted, insert command seen
    assign take = PAT_READY && (ctrl_q[BEI_CTRL_LOADED] ? PAT_VALID : 1'b1);
    assign cmd  = WR && ADDR == BEI_OFS_CMD && WDATA[BEI_CMD_INSERT];

    chk_stream_hold: assert property (DATA_VALID && !DATA_READY |=>
        DATA_VALID && $stable(DATA_OUT)) else $error("output bit dropped during stall");
    chk_fill_stop: assert property ((DATA_VALID && !DATA_READY && take) ##1 !DATA_READY
        |-> ##[0:1] !PAT_READY) else $error("source still accepted while buffer full");
    chk_alt_pattern: assert property (DATA_VALID && DATA_READY && rx_n >= 3'h5
        && !ctrl_q[BEI_CTRL_EN] && !ctrl_q[BEI_CTRL_LOADED] |-> DATA_OUT != rx_last)
        else $error("fallback stream not alternating");
    chk_lamp_arm: assert property (cmd && ctrl_q[BEI_CTRL_EN] && !ctrl_q[BEI_CTRL_REPEAT]
        ##1 (ctrl_q[BEI_CTRL_LOADED] && !PAT_VALID)[*2] |-> INSERT_LAMP)
        else $error("lamp not lit while single error armed");
    chk_lamp_idle: assert property ((!ctrl_q[BEI_CTRL_EN] || ctrl_q[BEI_CTRL_REPEAT])[*3]
        |-> !INSERT_LAMP) else $error("lamp lit outside single mode");
    chk_lamp_cause: assert property ($rose(INSERT_LAMP) |-> $past(cmd) || $past(cmd, 2))
        else $error("lamp rose without insert command");
    chk_sync_div1: assert property (!ctrl_q[BEI_CTRL_SRC_DET] && ctrl_q[10:8] == 3'h0
        |=> SYNC_OUT == $past(take)) else $error("undivided sync not tied to taken bits");
    chk_sync_det: assert property ((ctrl_q[BEI_CTRL_SRC_DET] && !DET_TICK)[*8]
        |-> !SYNC_OUT) else $error("detector sync pulse without detector tick");
    chk_gen_gap: assert property (!ctrl_q[BEI_CTRL_SRC_DET] && ctrl_q[10:8] inside {[3'h1:3'h5]}
        && SYNC_OUT |=> !SYNC_OUT) else $error("divided sync pulses too close");

    // Main scenarios reached
    cov_lamp: cover property ($rose(INSERT_LAMP));
    cov_sync_det: cover property (ctrl_q[BEI_CTRL_SRC_DET] && SYNC_OUT);
    cov_full: cover property (DATA_VALID && !DATA_READY && !PAT_READY);
endmodule : bei_inserter_chk

bind bei_inserter bei_inserter_chk bei_inserter_chk_i (.MCLK, .RST_N, .ADDR, .WDATA, .WR,
    .PAT_VALID, .PAT_READY, .DATA_OUT, .DATA_VALID, .DATA_READY, .DET_TICK, .SYNC_OUT,
    .INSERT_LAMP);

// [bei_pkg.sv]
// Constants shared by the error inserter, its checker and the bench.
// Assumes one bit-rate clock and a plain register port of 32-bit words.
// Behaviour
// - Unloaded pattern outputs alternating zero and one
// - Two modes: single shot or repeat
// - Each single insert command corrupts one bit, unless one is already armed
// - Lamp output shows single insertion in progress
// - Repeat rate is one of eleven decades
// - Repeat insertion only while enable is on
// - Mean error spacing equals reciprocal of rate
// - Sync source is generator or detector timing
// - Sync divisors: generator list, detector 4/8/16
// - Pattern sync: one pulse per pattern repetition
package bei_pkg;

    // Register word offsets
    localparam logic [7:0] BEI_OFS_CTRL   = 8'h00;
    localparam logic [7:0] BEI_OFS_CMD    = 8'h04;
    localparam logic [7:0] BEI_OFS_PATLEN = 8'h08;
    localparam logic [7:0] BEI_OFS_STATUS = 8'h0C;

    // Control field positions
    localparam int BEI_CTRL_EN      = 0;
    localparam int BEI_CTRL_REPEAT  = 1;
    localparam int BEI_CTRL_LOADED  = 2;
    localparam int BEI_CTRL_SRC_DET = 3;
    localparam int BEI_CTRL_RATE_LO = 4;
    localparam int BEI_CTRL_GDIV_LO = 8;
    localparam int BEI_CTRL_DDIV_LO = 11;
    localparam int BEI_CMD_INSERT   = 0;
    localparam int BEI_STAT_CNT_LO  = 16;

    // Values after reset
    localparam logic [12:0] BEI_CTRL_RESET   = 13'h0000;
    localparam logic [20:0] BEI_PATLEN_RESET = 21'h00007F;

    // Pattern length limits and the alternating fallback length
    localparam logic [20:0] BEI_PATLEN_MAX = 21'h13EC00;
    localparam logic [20:0] BEI_ALT_LEN    = 21'h000002;

    // Highest rate selection, 1E-12
    localparam logic [3:0] BEI_RATE_LAST = 4'hA;

    // Bits between errors for rates 1E-2 .. 1E-12
    localparam logic [39:0] BEI_RATE_PERIOD [0:10] = '{
        40'h0000000064, 40'h00000003E8, 40'h0000002710,
        40'h00000186A0, 40'h00000F4240, 40'h0000989680,
        40'h0005F5E100, 40'h003B9ACA00, 40'h02540BE400,
        40'h174876E800, 40'hE8D4A51000};

    // Divide selections for sync output
    typedef enum logic [2:0] {
        BEI_GDIV_1   = 3'h0,
        BEI_GDIV_2   = 3'h1,
        BEI_GDIV_4   = 3'h2,
        BEI_GDIV_8   = 3'h3,
        BEI_GDIV_16  = 3'h4,
        BEI_GDIV_64  = 3'h5,
        BEI_GDIV_PAT = 3'h6
    } bei_gdiv_t;

    typedef enum logic [1:0] {
        BEI_DDIV_4  = 2'h0,
        BEI_DDIV_8  = 2'h1,
        BEI_DDIV_16 = 2'h2
    } bei_ddiv_t;

    // Single-shot insertion states
    typedef enum logic [2:0] {
        BEI_SS_IDLE  = 3'b001,
        BEI_SS_ARMED = 3'b010,
        BEI_SS_HIT   = 3'b100
    } bei_ss_t;

endpackage : bei_pkg

// [testbench.sv]
// Self-checking bench: register calls and stream scenarios for the inserter.
// Assumes the package, design and far-side model are compiled first.
`timescale 1ns/10ps
module testbench;
    import bei_pkg::*;
    localparam int unsigned SHIFT = 2;
    logic        MCLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0;
    logic [7:0]  ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA, q;
    logic        PAT_DATA = 1'b0, PAT_VALID = 1'b0, PAT_READY, DATA_OUT, DATA_VALID;
    logic        DATA_READY, DET_TICK, SYNC_OUT, INSERT_LAMP, clr = 1'b0, tick_en = 1'b0;
    logic [1:0]  mode = 2'h0;
    int          ones, breaks, gap, ticks, n, syncs = 0, errors = 0, checks = 0, cycles = 0;
    int          divs [0:5] = '{1, 2, 4, 8, 16, 64};

    bei_inserter #(.RATE_SHIFT(SHIFT)) bei_inserter_i (.MCLK, .RST_N, .ADDR, .WDATA, .WR,
        .RD, .RDATA, .PAT_DATA, .PAT_VALID, .PAT_READY, .DATA_OUT, .DATA_VALID, .DATA_READY,
        .DET_TICK, .SYNC_OUT, .INSERT_LAMP);
    bei_far_end bei_far_end_i (.clk(MCLK), .clr, .mode, .tick_en, .data_out(DATA_OUT),
        .data_valid(DATA_VALID), .data_ready(DATA_READY), .det_tick(DET_TICK), .ones,
        .breaks, .gap, .ticks);

    // Clock, pulse counter and run limit
    initial
        forever #2.5 MCLK = ~MCLK;
    always @(posedge MCLK)
    begin
        syncs += (SYNC_OUT === 1'b1);
        cycles++;
        if (cycles == 60000)
        begin
            errors++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp32
    task automatic cmpn(input int got, input int exp);
        checks++;
        if (got != exp)
        begin
            errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmpn
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd
    task automatic do_reset;
        @(posedge MCLK);
        RST_N <= 1'b0;
        repeat (5) @(posedge MCLK);
        RST_N <= 1'b1;
    endtask : do_reset
    task automatic clear;
        #1 clr = 1'b1;
        @(posedge MCLK);
        #1 clr = 1'b0;
    endtask : clear
    task automatic wait_cyc(input int c);
        repeat (c) @(posedge MCLK);
    endtask : wait_cyc
    // Cycles from one sync pulse to the next, after two pulses of settling
    task automatic sync_gap(input int exp);
        repeat (3)
        begin
            n = 0;
            do
            begin
                @(posedge MCLK);
                #1 n++;
            end
            while (SYNC_OUT !== 1'b1 && n < 300);
        end
        cmpn(n, exp);
    endtask : sync_gap

    initial
    begin
        do_reset();
        rd(BEI_OFS_CTRL, q); cmp32(q, 32'h0);
        rd(BEI_OFS_PATLEN, q); cmp32(q, 32'h7F);
        rd(BEI_OFS_CMD, q); cmp32(q, 32'h0);
        rd(8'h10, q); cmp32(q, 32'h0);
        // Fallback stream through stalls and a full buffer
        clear();
        mode = 2'h1;
        wait_cyc(60);
        mode = 2'h2;
        wait_cyc(6);
        #1 cmp32({DATA_VALID, PAT_READY}, 32'h2);
        mode = 2'h1;
        wait_cyc(60);
        cmpn(breaks, 0);
        cmpn(ones > 40, 1);
        // Single errors on an all-zero stored pattern
        wr(BEI_OFS_CTRL, 32'h5);
        wait_cyc(6);
        clear();
        for (int i = 0; i < 3; i++)
        begin
            @(posedge MCLK);
            PAT_VALID <= 1'b0;
            wr(BEI_OFS_CMD, 32'h1);
            wait_cyc(2);
            #1 cmp32({31'h0, INSERT_LAMP}, 32'h1);
            @(posedge MCLK);
            PAT_VALID <= 1'b1;
            wait_cyc(12);
        end
        cmpn(ones, 3);
        rd(BEI_OFS_STATUS, q); cmp32({16'h0, q[31:16]}, 32'h3);
        wr(BEI_OFS_CTRL, 32'h4);
        wr(BEI_OFS_CMD, 32'h1);
        wait_cyc(12);
        cmpn(ones, 3);
        // Repeat mode spacing at the first three decades, receiver stalling
        for (int r = 0; r < 3; r++)
        begin
            wr(BEI_OFS_CTRL, 32'h7 | (r << 4));
            clear();
            n = 0;
            while (ones < 3 && n < 15000)
            begin
                @(posedge MCLK);
                n++;
            end
            cmpn(gap, int'(BEI_RATE_PERIOD[r] >> SHIFT));
            wr(BEI_OFS_CTRL, 32'h4);
        end
        wait_cyc(8);
        clear();
        wait_cyc(300);
        cmpn(ones, 0);
        // Generator sync divisors and pattern sync
        mode = 2'h0;
        for (int i = 0; i < 6; i++)
        begin
            wr(BEI_OFS_CTRL, i << 8);
            sync_gap(divs[i]);
        end
        wr(BEI_OFS_CTRL, 32'h600);
        sync_gap(2);
        wr(BEI_OFS_PATLEN, 32'h25);
        wr(BEI_OFS_CTRL, 32'h604);
        sync_gap(37);
        // Detector sync, fresh divider each time
        for (int i = 0; i < 3; i++)
        begin
            do_reset();
            wr(BEI_OFS_CTRL, 32'h8 | (i << 11));
            clear();
            syncs = 0;
            tick_en = 1'b1;
            n = 0;
            while (ticks < 3 * divs[i + 2] && n < 2000)
            begin
                @(posedge MCLK);
                n++;
            end
            tick_en = 1'b0;
            wait_cyc(12);
            cmpn(syncs, 3);
        end
        conclude();
    end
endmodule : testbench
